// file: pkg/iide_pkg.sv
// Shared constants and types of the integer decode and execute unit.
// Assumes a 32-bit single-issue core on one clock.
package iide_pkg;
	// Register-format layout; immediate and jump target overlay the low bits
	typedef struct packed {
		logic [5:0] major_instruction_code;
		logic [4:0] first_source_field;
		logic [4:0] second_operand_field;
		logic [4:0] destination_field;
		logic [4:0] shift_amount_field;
		logic [5:0] function_field;
	} iide_rfmt_t;
	// Sequencer states, Gray along fetch, execute, memory
	typedef enum logic [1:0] {S_FETCH = 2'h0, S_EXEC = 2'h1, S_MEM = 2'h3} iide_state_t;
	// Kinds of blocking memory sequence
	typedef enum logic [2:0] {K_ST = 3'h0, K_AT_RD = 3'h1, K_AT_WR = 3'h3, K_IR0 = 3'h2, K_IR1 = 3'h6} iide_kind_t;
	localparam int NREG = 32;
	localparam logic [4:0] SP_REG = 5'h1D;
	localparam logic [4:0] LINK_REG = 5'h1F;
	localparam logic [31:0] INSTR_BYTES = 32'h0000_0004;
	localparam logic [31:0] INTERRUPT_RETURN_EPILOGUE_POP = 32'h0000_0008;
	localparam int ST_IE = 0;
	localparam int ST_EXL = 1;
	localparam logic [5:0] LEAD_ALL = 6'h20;
	// Access sizes and their lane masks
	localparam logic [1:0] SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_TRI = 2'h2, SZ_WORD = 2'h3;
	localparam logic [3:0] M_BYTE = 4'h1, M_HALF = 4'h3, M_TRI = 4'h7, M_WORD = 4'hF;
	// Major codes
	localparam logic [5:0] OP_SPECIAL = 6'h00, OP_REGIMM = 6'h01, OP_J = 6'h02, OP_JAL = 6'h03;
	localparam logic [5:0] OP_BEQ = 6'h04, OP_BNE = 6'h05, OP_BLEZ = 6'h06, OP_BGTZ = 6'h07;
	localparam logic [5:0] OP_BEQL = 6'h14, OP_BNEL = 6'h15, OP_BLEZL = 6'h16, OP_BGTZL = 6'h17;
	localparam logic [5:0] OP_ADDIU = 6'h09, OP_SLTI = 6'h0A, OP_SLTIU = 6'h0B, OP_ANDI = 6'h0C;
	localparam logic [5:0] OP_ORI = 6'h0D, OP_XORI = 6'h0E, OP_LUI = 6'h0F, OP_SYS_CTRL = 6'h10;
	localparam logic [5:0] OP_SPECIAL2 = 6'h1C, OP_ATOMIC_BIT = 6'h1D;
	localparam logic [5:0] OP_LB = 6'h20, OP_LH = 6'h21, OP_LW = 6'h23, OP_LBU = 6'h24, OP_LHU = 6'h25;
	localparam logic [5:0] OP_SB = 6'h28, OP_SH = 6'h29, OP_SW = 6'h2B;
	// Function codes
	localparam logic [5:0] F_SLL = 6'h00, F_SRL = 6'h02, F_SRA = 6'h03, F_JR = 6'h08, F_JALR = 6'h09;
	localparam logic [5:0] F_MOVE_FROM_TOP = 6'h10, F_MOVE_TO_TOP = 6'h11;
	localparam logic [5:0] F_MOVE_FROM_BOT = 6'h12, F_MOVE_TO_BOT = 6'h13;
	localparam logic [5:0] F_MULT = 6'h18, F_MULTU = 6'h19, F_ADDU = 6'h21, F_SUBU = 6'h23;
	localparam logic [5:0] F_AND = 6'h24, F_OR = 6'h25, F_XOR = 6'h26, F_NOR = 6'h27;
	localparam logic [5:0] F_SLT = 6'h2A, F_SLTU = 6'h2B;
	localparam logic [5:0] F_SIGNED_ACC = 6'h00, F_UNSIGNED_ACC = 6'h01, F_PRODUCT_TO_REG = 6'h02;
	localparam logic [5:0] F_SIGNED_DED = 6'h04, F_UNSIGNED_DED = 6'h05;
	localparam logic [5:0] F_LEAD_ZEROS = 6'h20, F_LEAD_ONES = 6'h21, F_INT_RETURN = 6'h19;
endpackage

// file: hw/iide_core.sv
// Integer decode and execute unit: one instruction in flight, a
// non-blocking load and a background multiplier.
// Assumes fetch and data ports answer on clk_sys with ack pulses.
//
// Overview of operation
// - Instructions are aligned words, three layouts
// - Register layout: code, three registers, shift, function
// - Immediate 16 bits, jump target 26 bits
// - Stall consumers of a pending load
// - Address names lowest byte, endian dependent
// - Byte lanes from size and low bits
// - Illegal size and offset raise address error
// - Accumulator reads wait for the multiplier
// - Jumps and branches have one delay slot
// - Jump target: PC top nibble, field shifted
// - Register jumps take the full register
// - Branch target: slot address plus scaled offset
// - Untaken likely branch cancels its slot
// - Count leading ones, 32 when all set
// - Count leading zeros, 32 when zero
// - Product accumulate adds, no exception
// - Product deduct subtracts, no exception
// - Product to register writes low word
// - Superscalar inhibit noop is a plain noop
// - Atomic bit ops are one unsplittable sequence
// - Interrupt return pops state or chains
`timescale 1ns/1ps
`default_nettype none
module iide_core #(
	parameter logic [31:0] RESET_PC = 32'h0000_0000, // Start address
	parameter logic [31:0] CHAIN_PC = 32'h0000_0200, // Entry for a chained interrupt
	parameter logic [7:0] MUL_CYCLES = 8'h04 // Multiplier latency
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic big_endian_pin,
	input wire logic irq_pin,
	output logic imem_req_q,
	output logic [31:0] imem_addr_q,
	input wire logic imem_ack,
	input wire logic [31:0] imem_rdata,
	output logic dmem_req_q,
	output logic dmem_we_q,
	output logic [3:0] dmem_be_q,
	output logic [31:0] dmem_addr_q,
	output logic [31:0] dmem_wdata_q,
	input wire logic dmem_ack,
	input wire logic [31:0] dmem_rdata,
	output logic addr_err_q,
	output logic int_inhibit_q,
	output logic [31:0] proc_status_q
);
	iide_pkg::iide_state_t st_q; // Sequencer
	iide_pkg::iide_kind_t kind_q; // Blocking memory sequence in progress
	iide_pkg::iide_rfmt_t f; // Current instruction viewed as fields
	logic [31:0] rf_q [iide_pkg::NREG]; // General registers
	logic [31:0] ir_q, pc_q, br_tgt_q, acc_top_q, acc_bot_q;
	logic br_pend_q, null_q, ld_pend_q, ld_uns_q, at_set_q;
	logic [4:0] ld_reg_q;
	logic [1:0] ld_sz_q, lane_q;
	logic [2:0] at_bit_q;
	logic [63:0] mul_res_q;
	logic [7:0] mul_cnt_q;
	logic [1:0] big_sync_q, irq_sync_q; // Pin synchronisers
	logic [4:0] src, opd, dst, d_wreg;
	logic [31:0] simm, a, b, pc4, d_wval, d_tgt, d_base, ea, ld_sh, ld_val, at_mask;
	logic [63:0] prod_s, prod_u, d_acc;
	logic d_wr, d_br, d_take, d_likely, d_mem, d_ld, d_at, d_interrupt_return_epilogue, d_mul, d_mtt, d_mtb, d_accuse;
	logic [1:0] d_sz, low;
	logic [3:0] be;
	logic ok, mul_busy, stall, ex_go, live, chain;

	// Lane pattern: legal flag, byte enables, lowest lane of the item
	function automatic logic [6:0] lane_sel(input logic [1:0] sz, input logic [1:0] off, input logic big);
		logic [3:0] m;
		logic [3:0] le;
		logic lok;
		logic [1:0] lo2;
		case (sz)
			iide_pkg::SZ_BYTE: m = iide_pkg::M_BYTE;
			iide_pkg::SZ_HALF: m = iide_pkg::M_HALF;
			iide_pkg::SZ_TRI: m = iide_pkg::M_TRI;
			default: m = iide_pkg::M_WORD;
		endcase
		// Word at 0, triple at 0 or 1, half at 0 or 2, byte anywhere
		lok = (sz == iide_pkg::SZ_BYTE) || (sz == iide_pkg::SZ_HALF && !off[0]) ||
			(sz == iide_pkg::SZ_TRI && !off[1]) || (off == 2'h0);
		le = 4'(m << off);
		// Big endian: the named byte is the most significant lane
		lo2 = big ? 2'(2'h3 - off - sz) : off;
		return {lok, big ? {le[0], le[1], le[2], le[3]} : le, lo2};
	endfunction

	// Count of leading bits equal to the bit value given in one, scanning from bit 31
	function automatic logic [5:0] lead_cnt(input logic [31:0] x, input logic one);
		logic [5:0] n;
		logic run;
		n = 6'h00;
		run = 1'b1;
		for (int i = 31; i >= 0; i--) begin
			if (run && x[i] == one) begin
				n = n + 6'h01;
			end else begin
				run = 1'b0;
			end
		end
		return n;
	endfunction

	// Pins from outside pass two flops; only the second is read
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			big_sync_q <= 2'h0;
			irq_sync_q <= 2'h0;
		end else if (clk_en) begin
			big_sync_q <= {big_sync_q[0], big_endian_pin};
			irq_sync_q <= {irq_sync_q[0], irq_pin};
		end
	end

	// Decode of the held instruction word
	always_comb begin
		f = iide_pkg::iide_rfmt_t'(ir_q);
		src = f.first_source_field;
		opd = f.second_operand_field;
		dst = f.destination_field;
		simm = {{16{ir_q[15]}}, ir_q[15:0]};
		a = rf_q[src];
		b = rf_q[opd];
		pc4 = pc_q + iide_pkg::INSTR_BYTES;
		prod_s = {{32{a[31]}}, a} * {{32{b[31]}}, b};
		prod_u = {32'h0, a} * {32'h0, b};
		d_wr = 1'b0;
		d_wreg = dst;
		d_wval = 32'h0;
		d_br = 1'b0;
		d_take = 1'b0;
		d_likely = 1'b0;
		d_tgt = pc4 + {simm[29:0], 2'h0};
		d_mem = 1'b0;
		d_ld = 1'b0;
		d_at = 1'b0;
		d_interrupt_return_epilogue = 1'b0;
		d_sz = f.major_instruction_code[1:0];
		d_base = a;
		d_mul = 1'b0;
		d_acc = {acc_top_q, acc_bot_q};
		d_mtt = 1'b0;
		d_mtb = 1'b0;
		d_accuse = 1'b0;
		case (f.major_instruction_code)
			iide_pkg::OP_SPECIAL: begin
				d_wr = 1'b1;
				case (f.function_field)
					iide_pkg::F_SLL: d_wval = b << f.shift_amount_field;
					iide_pkg::F_SRL: d_wval = b >> f.shift_amount_field;
					iide_pkg::F_SRA: d_wval = 32'($signed(b) >>> f.shift_amount_field);
					iide_pkg::F_JR, iide_pkg::F_JALR: begin
						// Whole register is the new byte address
						d_wr = f.function_field[0];
						d_wval = pc4 + iide_pkg::INSTR_BYTES;
						d_br = 1'b1;
						d_take = 1'b1;
						d_tgt = a;
					end
					iide_pkg::F_MOVE_FROM_TOP: begin
						d_accuse = 1'b1;
						d_wval = acc_top_q;
					end
					iide_pkg::F_MOVE_FROM_BOT: begin
						d_accuse = 1'b1;
						d_wval = acc_bot_q;
					end
					iide_pkg::F_MOVE_TO_TOP, iide_pkg::F_MOVE_TO_BOT: begin
						d_wr = 1'b0;
						d_accuse = 1'b1;
						d_mtt = !f.function_field[1];
						d_mtb = f.function_field[1];
					end
					iide_pkg::F_MULT, iide_pkg::F_MULTU: begin
						d_wr = 1'b0;
						d_accuse = 1'b1;
						d_mul = 1'b1;
						d_acc = f.function_field[0] ? prod_u : prod_s;
					end
					iide_pkg::F_ADDU: d_wval = a + b;
					iide_pkg::F_SUBU: d_wval = a - b;
					iide_pkg::F_AND: d_wval = a & b;
					iide_pkg::F_OR: d_wval = a | b;
					iide_pkg::F_XOR: d_wval = a ^ b;
					iide_pkg::F_NOR: d_wval = ~(a | b);
					iide_pkg::F_SLT: d_wval = {31'h0, $signed(a) < $signed(b)};
					iide_pkg::F_SLTU: d_wval = {31'h0, a < b};
					default: d_wr = 1'b0;
				endcase
			end
			iide_pkg::OP_REGIMM: begin
				// Less-than-zero and at-least-zero, likely and linking forms
				d_br = (opd[3:2] == 2'h0);
				d_likely = opd[1];
				d_take = a[31] ^ opd[0];
				d_wr = d_br && opd[4];
				d_wreg = iide_pkg::LINK_REG;
				d_wval = pc4 + iide_pkg::INSTR_BYTES;
			end
			iide_pkg::OP_J, iide_pkg::OP_JAL: begin
				d_br = 1'b1;
				d_take = 1'b1;
				d_tgt = {pc_q[31:28], ir_q[25:0], 2'h0};
				d_wr = f.major_instruction_code[0];
				d_wreg = iide_pkg::LINK_REG;
				d_wval = pc4 + iide_pkg::INSTR_BYTES;
			end
			iide_pkg::OP_BEQ, iide_pkg::OP_BNE, iide_pkg::OP_BLEZ, iide_pkg::OP_BGTZ,
			iide_pkg::OP_BEQL, iide_pkg::OP_BNEL, iide_pkg::OP_BLEZL, iide_pkg::OP_BGTZL: begin
				d_br = 1'b1;
				d_likely = f.major_instruction_code[4];
				case (f.major_instruction_code[1:0])
					2'h0: d_take = (a == b);
					2'h1: d_take = (a != b);
					2'h2: d_take = a[31] || (a == 32'h0);
					default: d_take = !a[31] && (a != 32'h0);
				endcase
			end
			iide_pkg::OP_ADDIU, iide_pkg::OP_SLTI, iide_pkg::OP_SLTIU, iide_pkg::OP_ANDI,
			iide_pkg::OP_ORI, iide_pkg::OP_XORI, iide_pkg::OP_LUI: begin
				d_wr = 1'b1;
				d_wreg = opd;
				case (f.major_instruction_code)
					iide_pkg::OP_ADDIU: d_wval = a + simm;
					iide_pkg::OP_SLTI: d_wval = {31'h0, $signed(a) < $signed(simm)};
					iide_pkg::OP_SLTIU: d_wval = {31'h0, a < simm};
					iide_pkg::OP_ANDI: d_wval = a & {16'h0, ir_q[15:0]};
					iide_pkg::OP_ORI: d_wval = a | {16'h0, ir_q[15:0]};
					iide_pkg::OP_XORI: d_wval = a ^ {16'h0, ir_q[15:0]};
					default: d_wval = {ir_q[15:0], 16'h0};
				endcase
			end
			iide_pkg::OP_SPECIAL2: begin
				d_accuse = 1'b1;
				d_mul = 1'b1;
				case (f.function_field)
					iide_pkg::F_SIGNED_ACC: d_acc = d_acc + prod_s;
					iide_pkg::F_UNSIGNED_ACC: d_acc = d_acc + prod_u;
					iide_pkg::F_SIGNED_DED: d_acc = d_acc - prod_s;
					iide_pkg::F_UNSIGNED_DED: d_acc = d_acc - prod_u;
					default: begin
						// Register results; accumulator left as it stands
						d_accuse = 1'b0;
						d_mul = 1'b0;
						d_wr = 1'b1;
						if (f.function_field == iide_pkg::F_PRODUCT_TO_REG) begin
							d_wval = prod_s[31:0];
						end else if (f.function_field == iide_pkg::F_LEAD_ONES) begin
							d_wval = {26'h0, lead_cnt(a, 1'b1)};
						end else if (f.function_field == iide_pkg::F_LEAD_ZEROS) begin
							d_wval = {26'h0, lead_cnt(a, 1'b0)};
						end else begin
							d_wr = 1'b0;
						end
					end
				endcase
			end
			iide_pkg::OP_SYS_CTRL: begin
				// Return pops two stack words, so it uses the data port
				d_interrupt_return_epilogue = ir_q[25] && (f.function_field == iide_pkg::F_INT_RETURN);
				d_mem = d_interrupt_return_epilogue;
				d_sz = iide_pkg::SZ_WORD;
				d_base = rf_q[iide_pkg::SP_REG];
			end
			iide_pkg::OP_ATOMIC_BIT: begin
				d_mem = 1'b1;
				d_at = 1'b1;
				d_sz = iide_pkg::SZ_BYTE;
			end
			iide_pkg::OP_LB, iide_pkg::OP_LH, iide_pkg::OP_LW, iide_pkg::OP_LBU, iide_pkg::OP_LHU: begin
				d_mem = 1'b1;
				d_ld = 1'b1;
			end
			iide_pkg::OP_SB, iide_pkg::OP_SH, iide_pkg::OP_SW: d_mem = 1'b1;
			default: d_wr = 1'b0;
		endcase
		ea = d_base + (d_interrupt_return_epilogue ? 32'h0 : simm);
		{ok, be, low} = lane_sel(d_sz, ea[1:0], big_sync_q[1]);
		mul_busy = (mul_cnt_q != 8'h00);
		// Hold while a pending load owns a named register or the data port
		stall = (ld_pend_q && (ld_reg_q == src || ld_reg_q == opd || ld_reg_q == dst ||
			ld_reg_q == iide_pkg::LINK_REG || d_mem)) || (mul_busy && d_accuse);
		ex_go = (st_q == iide_pkg::S_EXEC) && !stall;
		live = ex_go && !null_q;
	end

	// Load alignment and extension from the captured lane
	always_comb begin
		ld_sh = dmem_rdata >> {lane_q, 3'h0};
		case (ld_sz_q)
			iide_pkg::SZ_BYTE: ld_val = {{24{ld_sh[7] && !ld_uns_q}}, ld_sh[7:0]};
			iide_pkg::SZ_HALF: ld_val = {{16{ld_sh[15] && !ld_uns_q}}, ld_sh[15:0]};
			default: ld_val = ld_sh;
		endcase
		at_mask = 32'h1 << {lane_q, at_bit_q};
		chain = irq_sync_q[1] && proc_status_q[iide_pkg::ST_IE];
	end

	// Register file: execute write, load return, stack pop; zero stays zero
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			for (int i = 0; i < iide_pkg::NREG; i++) begin
				rf_q[i] <= 32'h0;
			end
		end else if (clk_en) begin
			if (ld_pend_q && dmem_ack && st_q != iide_pkg::S_MEM && ld_reg_q != 5'h00) begin
				rf_q[ld_reg_q] <= ld_val;
			end
			if (live && d_wr && d_wreg != 5'h00) begin
				rf_q[d_wreg] <= d_wval;
			end
			if (st_q == iide_pkg::S_MEM && dmem_ack && kind_q == iide_pkg::K_IR1) begin
				rf_q[iide_pkg::SP_REG] <= rf_q[iide_pkg::SP_REG] + iide_pkg::INTERRUPT_RETURN_EPILOGUE_POP;
			end
		end
	end

	// Multiplier runs beside the pipe and lands the pair when done
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			mul_cnt_q <= 8'h00;
			mul_res_q <= 64'h0;
			acc_top_q <= 32'h0;
			acc_bot_q <= 32'h0;
		end else if (clk_en) begin
			if (live && d_mul) begin
				mul_cnt_q <= MUL_CYCLES;
				mul_res_q <= d_acc;
			end else if (mul_busy) begin
				mul_cnt_q <= mul_cnt_q - 8'h01;
				if (mul_cnt_q == 8'h01) begin
					{acc_top_q, acc_bot_q} <= mul_res_q;
				end
			end
			if (live && d_mtt) begin
				acc_top_q <= a;
			end
			if (live && d_mtb) begin
				acc_bot_q <= a;
			end
		end
	end

	// Sequencer: fetch, execute, and the blocking memory sequences
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			st_q <= iide_pkg::S_FETCH;
			kind_q <= iide_pkg::K_ST;
			ir_q <= 32'h0;
			pc_q <= RESET_PC;
			br_tgt_q <= 32'h0;
			br_pend_q <= 1'b0;
			null_q <= 1'b0;
			ld_pend_q <= 1'b0;
			ld_uns_q <= 1'b0;
			ld_reg_q <= 5'h00;
			ld_sz_q <= iide_pkg::SZ_WORD;
			lane_q <= 2'h0;
			at_bit_q <= 3'h0;
			at_set_q <= 1'b0;
			imem_req_q <= 1'b1;
			imem_addr_q <= RESET_PC;
			dmem_req_q <= 1'b0;
			dmem_we_q <= 1'b0;
			dmem_be_q <= 4'h0;
			dmem_addr_q <= 32'h0;
			dmem_wdata_q <= 32'h0;
			addr_err_q <= 1'b0;
			int_inhibit_q <= 1'b0;
			proc_status_q <= 32'h0;
		end else if (clk_en) begin
			addr_err_q <= 1'b0;
			if (ld_pend_q && dmem_ack && st_q != iide_pkg::S_MEM) begin
				ld_pend_q <= 1'b0;
				dmem_req_q <= 1'b0;
			end
			case (st_q)
				iide_pkg::S_FETCH: begin
					if (imem_ack) begin
						ir_q <= imem_rdata;
						imem_req_q <= 1'b0;
						st_q <= iide_pkg::S_EXEC;
					end
				end
				iide_pkg::S_EXEC: begin
					if (ex_go) begin
						// Slot after a taken transfer runs, then the target
						pc_q <= br_pend_q ? br_tgt_q : pc4;
						imem_addr_q <= br_pend_q ? br_tgt_q : pc4;
						br_pend_q <= live && d_br && d_take;
						br_tgt_q <= d_tgt;
						null_q <= live && d_br && d_likely && !d_take;
						st_q <= iide_pkg::S_FETCH;
						imem_req_q <= 1'b1;
						if (live && d_mem && !ok) begin
							addr_err_q <= 1'b1;
						end else if (live && d_mem) begin
							dmem_req_q <= 1'b1;
							dmem_we_q <= !d_ld && !d_at && !d_interrupt_return_epilogue;
							dmem_be_q <= be;
							dmem_addr_q <= {ea[31:2], 2'h0};
							dmem_wdata_q <= b << {low, 3'h0};
							lane_q <= low;
							ld_pend_q <= d_ld;
							ld_reg_q <= opd;
							ld_sz_q <= d_sz;
							ld_uns_q <= f.major_instruction_code[2];
							at_bit_q <= opd[2:0];
							at_set_q <= opd[4];
							int_inhibit_q <= d_at;
							if (!d_ld) begin
								// Stores, atomics and returns block the pipe
								st_q <= iide_pkg::S_MEM;
								imem_req_q <= 1'b0;
								kind_q <= d_at ? iide_pkg::K_AT_RD :
									(d_interrupt_return_epilogue ? iide_pkg::K_IR0 : iide_pkg::K_ST);
							end
						end
					end
				end
				default: begin
					if (dmem_ack) begin
						dmem_req_q <= 1'b0;
						st_q <= iide_pkg::S_FETCH;
						imem_req_q <= 1'b1;
						case (kind_q)
							iide_pkg::K_AT_RD: begin
								// Write back at once, interrupts still held off
								st_q <= iide_pkg::S_MEM;
								imem_req_q <= 1'b0;
								dmem_req_q <= 1'b1;
								dmem_we_q <= 1'b1;
								dmem_wdata_q <= at_set_q ? (dmem_rdata | at_mask) : (dmem_rdata & ~at_mask);
								kind_q <= iide_pkg::K_AT_WR;
							end
							iide_pkg::K_AT_WR: int_inhibit_q <= 1'b0;
							iide_pkg::K_IR0: begin
								st_q <= iide_pkg::S_MEM;
								imem_req_q <= 1'b0;
								proc_status_q <= dmem_rdata;
								dmem_req_q <= 1'b1;
								dmem_addr_q <= dmem_addr_q + iide_pkg::INSTR_BYTES;
								kind_q <= iide_pkg::K_IR1;
							end
							iide_pkg::K_IR1: begin
								// A pending interrupt is entered without leaving
								pc_q <= chain ? CHAIN_PC : dmem_rdata;
								imem_addr_q <= chain ? CHAIN_PC : dmem_rdata;
								proc_status_q[iide_pkg::ST_EXL] <= chain;
							end
							default: dmem_we_q <= 1'b0;
						endcase
					end
				end
			endcase
		end
	end

	property p_load_use; @(posedge clk_sys) disable iff (!reset_n)
		st_q == iide_pkg::S_EXEC && ld_pend_q && ld_reg_q == src |-> !ex_go;
	endproperty
	a_load_use: assert property (p_load_use) else $error("load consumer not stalled");
	property p_acc_wait; @(posedge clk_sys) disable iff (!reset_n || !clk_en)
		st_q == iide_pkg::S_EXEC && mul_busy && d_accuse |=> st_q == iide_pkg::S_EXEC;
	endproperty
	a_acc_wait: assert property (p_acc_wait) else $error("accumulator read before product");
	property p_addr_err; @(posedge clk_sys) disable iff (!reset_n || !clk_en)
		live && d_mem && !ok |=> addr_err_q && !dmem_req_q;
	endproperty
	a_addr_err: assert property (p_addr_err) else $error("bad alignment reached memory");
	property p_word_lanes; @(posedge clk_sys) disable iff (!reset_n)
		dmem_req_q && dmem_be_q == iide_pkg::M_WORD |-> dmem_addr_q[1:0] == 2'h0 && !addr_err_q;
	endproperty
	a_word_lanes: assert property (p_word_lanes) else $error("word lanes wrong");
	property p_delay_slot; @(posedge clk_sys) disable iff (!reset_n || !clk_en)
		ex_go && br_pend_q |=> pc_q == $past(br_tgt_q) && !br_pend_q ##0 $past(live) == !$past(null_q);
	endproperty
	a_delay_slot: assert property (p_delay_slot) else $error("slot not followed by target");
	property p_nullify; @(posedge clk_sys) disable iff (!reset_n)
		ex_go && null_q |-> !live;
	endproperty
	a_nullify: assert property (p_nullify) else $error("cancelled slot took effect");
	property p_jump_tgt; @(posedge clk_sys) disable iff (!reset_n || !clk_en)
		live && f.major_instruction_code == iide_pkg::OP_J |=> br_pend_q && br_tgt_q[31:28] == $past(pc_q[31:28]) &&
			br_tgt_q[27:2] == $past(ir_q[25:0]);
	endproperty
	a_jump_tgt: assert property (p_jump_tgt) else $error("jump target wrong");
	property p_atomic; @(posedge clk_sys) disable iff (!reset_n)
		st_q == iide_pkg::S_MEM && (kind_q == iide_pkg::K_AT_RD || kind_q == iide_pkg::K_AT_WR) |-> int_inhibit_q;
	endproperty
	a_atomic: assert property (p_atomic) else $error("atomic sequence open to interrupts");
endmodule
`default_nettype wire

// file: dv/iide_mem_model.sv
// Fetch and data memory model on the far side of the decode unit.
// Assumes the bench preloads the program and reads data words back.
`timescale 1ns/1ps
`default_nettype none
module iide_mem_model (
	input wire logic clk_sys,
	input wire logic [3:0] dwait,
	input wire logic imem_req_q,
	input wire logic [31:0] imem_addr_q,
	output logic imem_ack,
	output logic [31:0] imem_rdata,
	input wire logic dmem_req_q,
	input wire logic dmem_we_q,
	input wire logic [3:0] dmem_be_q,
	input wire logic [31:0] dmem_addr_q,
	input wire logic [31:0] dmem_wdata_q,
	output logic dmem_ack,
	output logic [31:0] dmem_rdata
);
	logic [31:0] im [256]; // Program words
	logic [31:0] dm [256]; // Data words
	logic [3:0] wait_q; // Cycles the data request has waited
	initial begin
		imem_ack = 1'b0;
		dmem_ack = 1'b0;
		imem_rdata = 32'h0;
		dmem_rdata = 32'h0;
		wait_q = 4'h0;
	end
	// Fetch answers after one cycle; read data toggles outside the answer
	always @(posedge clk_sys) begin
		imem_ack <= imem_req_q && !imem_ack;
		imem_rdata <= (imem_req_q && !imem_ack) ? im[imem_addr_q[9:2]] : ~imem_rdata;
	end
	// Data answers after dwait plus one cycles, so interlocks see slow memory too
	always @(posedge clk_sys) begin
		wait_q <= (dmem_req_q && !dmem_ack) ? wait_q + 4'h1 : 4'h0;
		dmem_ack <= dmem_req_q && !dmem_ack && wait_q >= dwait;
		dmem_rdata <= (dmem_req_q && !dmem_ack && wait_q >= dwait) ? dm[dmem_addr_q[9:2]] : ~dmem_rdata;
		// Only enabled lanes are written
		for (int b = 0; b < 4; b++) begin
			if (dmem_req_q && dmem_ack && dmem_we_q && dmem_be_q[b]) begin
				dm[dmem_addr_q[9:2]][8 * b +: 8] <= dmem_wdata_q[8 * b +: 8];
			end
		end
	end
endmodule
`default_nettype wire

// file: dv/test_integer_instr_decode_execute.sv
// Self-checking bench: small programs run, results are read from data memory.
// Assumes the memory model answers every fetch and data request.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("wrong value %s exp %h got %h", n, e, g); end end
`define I(o, s, t, m) prog.push_back({iide_pkg::o, 5'(s), 5'(t), 16'(m)});
`define R(o, s, t, d, f) prog.push_back({iide_pkg::o, 5'(s), 5'(t), 5'(d), 5'h00, iide_pkg::f});
`define D(i) iide_mem_model_i.dm[i]
module test_integer_instr_decode_execute;
	logic clk_sys = 1'b0; // 8 ns period
	logic reset_n = 1'b0;
	logic big_endian_pin = 1'b0;
	logic irq_pin = 1'b0; // Pending interrupt, only looked at by the return
	logic [3:0] dwait = 4'h0; // Data answer delay
	logic imem_req_q, imem_ack, dmem_req_q, dmem_we_q, dmem_ack, addr_err_q, int_inhibit_q;
	logic [31:0] imem_addr_q, imem_rdata, dmem_addr_q, dmem_wdata_q, dmem_rdata, proc_status_q;
	logic [3:0] dmem_be_q;
	int failures = 0, checks = 0, errs = 0, ninh = 0, cyc = 0;
	logic [31:0] prog [$]; // Program under construction
	always #4 clk_sys = ~clk_sys;
	iide_core iide_core_i (.clk_sys, .reset_n, .clk_en(1'b1), .big_endian_pin, .irq_pin, .imem_req_q,
		.imem_addr_q, .imem_ack, .imem_rdata, .dmem_req_q, .dmem_we_q, .dmem_be_q, .dmem_addr_q,
		.dmem_wdata_q, .dmem_ack, .dmem_rdata, .addr_err_q, .int_inhibit_q, .proc_status_q);
	iide_mem_model iide_mem_model_i (.clk_sys, .dwait, .imem_req_q, .imem_addr_q, .imem_ack, .imem_rdata,
		.dmem_req_q, .dmem_we_q, .dmem_be_q, .dmem_addr_q, .dmem_wdata_q, .dmem_ack, .dmem_rdata);
	// Address error pulses and inhibit cycles, counted per program
	always @(posedge clk_sys) begin
		errs += (addr_err_q === 1'b1);
		ninh += (int_inhibit_q === 1'b1);
	end
	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Append a completion marker and a parking loop, reset, run to the marker
	task automatic run(input logic e);
		int k;
		k = 0;
		`I(OP_ADDIU, 0, 30, 16'h0055)
		`I(OP_SW, 0, 30, 16'h03FC)
		`I(OP_BEQ, 0, 0, 16'hFFFF)
		prog.push_back(32'h0);
		foreach (prog[j]) iide_mem_model_i.im[j] = prog[j];
		foreach (iide_mem_model_i.dm[j]) iide_mem_model_i.dm[j] = 32'h0;
		@(negedge clk_sys);
		reset_n = 1'b0;
		big_endian_pin = e;
		repeat (10) @(negedge clk_sys);
		errs = 0;
		ninh = 0;
		reset_n = 1'b1;
		while (`D(255) !== 32'h55 && k < 4000) begin
			@(negedge clk_sys);
			k++;
		end
		`CHK("completion", 1'b1, k < 4000)
		prog.delete();
	endtask
	// Leading ones and zeros, including both all-bits cases
	task automatic t_count();
		`I(OP_LUI, 0, 1, 16'hFFF0)
		`I(OP_ADDIU, 0, 5, 16'hFFFF)
		`I(OP_ADDIU, 0, 7, 16'h0001)
		`R(OP_SPECIAL2, 1, 2, 2, F_LEAD_ONES)
		`R(OP_SPECIAL2, 0, 3, 3, F_LEAD_ZEROS)
		`R(OP_SPECIAL2, 5, 4, 4, F_LEAD_ONES)
		`R(OP_SPECIAL2, 7, 6, 6, F_LEAD_ZEROS)
		`I(OP_SW, 0, 2, 16'h0000)
		`I(OP_SW, 0, 3, 16'h0004)
		`I(OP_SW, 0, 4, 16'h0008)
		`I(OP_SW, 0, 6, 16'h000C)
		run(1'b0);
		`CHK("ones", 32'hC, `D(0))
		`CHK("zeros", 32'h20, `D(1))
		`CHK("all ones", 32'h20, `D(2))
		`CHK("one bit", 32'h1F, `D(3))
	endtask
	// Lanes in both byte orders, misaligned half, load-use, atomic bit ops
	task automatic t_lanes();
		for (int e = 0; e < 2; e++) begin
			dwait = 4'h3; // Slow answers stretch the interlock
			`I(OP_ADDIU, 0, 1, 16'h00AB)
			`I(OP_SB, 0, 1, 16'h0001)
			`I(OP_SH, 0, 1, 16'h0006)
			`I(OP_SH, 0, 1, 16'h0009)
			`I(OP_LW, 0, 3, 16'h0004)
			`R(OP_SPECIAL, 3, 1, 4, F_ADDU)
			`I(OP_LB, 0, 5, 16'h0001)
			`I(OP_SW, 0, 5, 16'h0010)
			`I(OP_SW, 0, 4, 16'h000C)
			`I(OP_SW, 0, 1, 16'h001C)
			`I(OP_ATOMIC_BIT, 0, 19, 16'h0018)
			`I(OP_ATOMIC_BIT, 0, 0, 16'h001C)
			run(e[0]);
			`CHK("byte", e ? 32'h00AB0000 : 32'h0000AB00, `D(0))
			`CHK("half", e ? 32'h000000AB : 32'h00AB0000, `D(1))
			`CHK("dropped", 32'h0, `D(2))
			`CHK("addr err", 1, errs)
			`CHK("load use", e ? 32'h00000156 : 32'h00AB00AB, `D(3))
			`CHK("load byte", 32'hFFFFFFAB, `D(4))
			`CHK("bit set", e ? 32'h08000000 : 32'h00000008, `D(6))
			`CHK("bit clear", e ? 32'h000000AB : 32'h000000AA, `D(7))
			`CHK("inhibit", 1'b1, ninh > 0)
		end
		dwait = 4'h0;
	endtask
	// Accumulator read straight after each accumulate and deduct kind
	task automatic t_mult();
		int r [6] = '{3, 4, 5, 7, 8, 6};
		logic [31:0] x [6] = '{32'hFFFFFFFF, 32'hFFFFFFF1, 32'hFFFFFFD8, 32'h4, 32'hFFFFFFD8, 32'hFFFFFFF1};
		`I(OP_ADDIU, 0, 1, 16'hFFFD)
		`I(OP_ADDIU, 0, 2, 16'h0005)
		`R(OP_SPECIAL2, 1, 2, 0, F_SIGNED_ACC)
		`R(OP_SPECIAL, 0, 0, 3, F_MOVE_FROM_TOP)
		`R(OP_SPECIAL, 0, 0, 4, F_MOVE_FROM_BOT)
		`R(OP_SPECIAL2, 2, 2, 0, F_UNSIGNED_DED)
		`R(OP_SPECIAL, 0, 0, 5, F_MOVE_FROM_BOT)
		`R(OP_SPECIAL2, 1, 2, 0, F_UNSIGNED_ACC)
		`R(OP_SPECIAL, 0, 0, 7, F_MOVE_FROM_TOP)
		`R(OP_SPECIAL2, 1, 2, 0, F_SIGNED_DED)
		`R(OP_SPECIAL, 0, 0, 8, F_MOVE_FROM_BOT)
		`R(OP_SPECIAL2, 1, 2, 6, F_PRODUCT_TO_REG)
		foreach (r[i]) `I(OP_SW, 0, r[i], 4 * i)
		run(1'b0);
		foreach (x[i]) `CHK("product", x[i], `D(i))
	endtask
	// Delay slots, cancelled likely slot, jump and register jump targets
	task automatic t_branch();
		int r [6] = '{2, 3, 4, 5, 6, 8};
		logic [31:0] x [6] = '{32'h7, 32'h0, 32'h0, 32'h6, 32'h0, 32'h3};
		`I(OP_ADDIU, 0, 1, 16'h0001)
		`I(OP_BEQ, 0, 0, 16'h0002)
		`I(OP_ADDIU, 0, 2, 16'h0007)
		`I(OP_ADDIU, 0, 3, 16'h0009)
		`I(OP_BNEL, 0, 0, 16'h0001)
		`I(OP_ADDIU, 0, 4, 16'h0005)
		prog.push_back({iide_pkg::OP_J, 26'h0000009});
		`I(OP_ADDIU, 0, 5, 16'h0006)
		`I(OP_ADDIU, 0, 6, 16'h0001)
		prog.push_back(32'h00000040); // Superscalar inhibit noop
		`I(OP_ADDIU, 0, 7, 16'h0034)
		`R(OP_SPECIAL, 7, 0, 0, F_JR)
		`I(OP_ADDIU, 0, 8, 16'h0003)
		foreach (r[i]) `I(OP_SW, 0, r[i], 4 * i)
		run(1'b0);
		foreach (x[i]) `CHK("flow", x[i], `D(i))
	endtask
	// Interrupt return pops status and pc, or chains when a request waits
	task automatic t_interrupt_return_epilogue();
		for (int q = 0; q < 2; q++) begin
			irq_pin = q[0];
			`I(OP_ADDIU, 0, 29, 16'h0100)
			`I(OP_ADDIU, 0, 9, 16'h0003)
			`I(OP_SW, 0, 9, 16'h0100)
			`I(OP_ADDIU, 0, 10, 16'h0018)
			`I(OP_SW, 0, 10, 16'h0104)
			prog.push_back({iide_pkg::OP_SYS_CTRL, 20'h80000, iide_pkg::F_INT_RETURN});
			`I(OP_SW, 0, 29, 16'h0000)
			while (prog.size() < 128) prog.push_back(32'h0); // Pad up to the chained entry
			run(1'b0);
			`CHK("popped sp", q ? 32'h0 : 32'h108, `D(0))
			`CHK("status", q ? 32'h3 : 32'h1, proc_status_q)
		end
	endtask
	initial begin
		t_count();
		t_lanes();
		t_mult();
		t_branch();
		t_interrupt_return_epilogue();
		report_and_stop();
	end
	// Hang guard well above the summed program lengths
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			report_and_stop();
		end
	end
endmodule
`default_nettype wire
